// ===== src/tcie_map.vh
`ifndef TCIE_MAP_VH
`define TCIE_MAP_VH

// register word addresses on the serial register port
`define TCIE_ADDR_W 6
`define TCIE_DATA_W 24
`define TCIE_OFS_MID_EN 6'h27
`define TCIE_OFS_UPPER_EN 6'h28
`define TCIE_RST_MID_EN 24'h000000
`define TCIE_RST_UPPER_EN 24'h000000

// number of threshold subfields, two enable bits each
`define TCIE_NSUB 24

// mid_input_irq_enables fields
`define TCIE_SWITCH_INPUT_18_LSB 0
`define TCIE_SWITCH_INPUT_18_MSB 5
`define TCIE_SWITCH_INPUT_19_LSB 6
`define TCIE_SWITCH_INPUT_19_MSB 11
`define TCIE_IN20_LSB 12
`define TCIE_IN20_MSB 17
`define TCIE_IN21_LSB 18
`define TCIE_IN21_MSB 23

// upper_input_and_supply_irq_enables fields
`define TCIE_SWITCH_INPUT_22_LSB 0
`define TCIE_SWITCH_INPUT_22_MSB 5
`define TCIE_SWITCH_INPUT_23_LSB 6
`define TCIE_SWITCH_INPUT_23_MSB 15
`define TCIE_VS0_LSB 16
`define TCIE_VS0_MSB 19
`define TCIE_VS1_LSB 20
`define TCIE_VS1_MSB 23

// subfield codes
`define TCIE_CODE_NONE 2'h0
`define TCIE_CODE_RISE 2'h1
`define TCIE_CODE_FALL 2'h2
`define TCIE_CODE_BOTH 2'h3

`endif

// ===== src/tcie_edge.v
`timescale 1ns/1ns
`default_nettype none
// one threshold subfield: remembers the last comparison and flags an enabled crossing
module tcie_edge (
	input wire clk,
	input wire rst_n,
	input wire sample_stb,
	input wire above,
	input wire [1:0] enable_code,
	output wire hit
);
	reg prev_r;
	reg primed_r;
	wire rise;
	wire fall;

	assign rise = primed_r & above & ~prev_r;
	assign fall = primed_r & ~above & prev_r;
	assign hit = sample_stb & ((enable_code[0] & rise) | (enable_code[1] & fall));

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			primed_r <= 1'b0;
		end else if (sample_stb) begin
			prev_r <= above;
			primed_r <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== src/tcie_top.v
`timescale 1ns/1ns
`default_nettype none
`include "tcie_map.vh"
module tcie_top (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire [`TCIE_ADDR_W-1:0] REG_ADDR,
	input wire [`TCIE_DATA_W-1:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [`TCIE_DATA_W-1:0] REG_RDATA,
	output reg REG_RD_VALID,
	input wire SAMPLE_STB,
	input wire [`TCIE_NSUB-1:0] ABOVE_THRESHOLD,
	output reg [`TCIE_NSUB-1:0] CROSSING_HIT,
	output reg CROSSING_IRQ
);
	reg rst_meta_r;
	reg rst_sync_r;
	reg [`TCIE_DATA_W-1:0] mid_input_irq_enables_r;
	reg [`TCIE_DATA_W-1:0] upper_input_and_supply_irq_enables_r;
	reg [`TCIE_DATA_W-1:0] rdata_nxt;
	wire [2*`TCIE_NSUB-1:0] enable_pairs;
	wire [`TCIE_NSUB-1:0] hit_vec;
	wire [5:0] input18_crossing_enable;
	wire [5:0] input19_crossing_enable;
	wire [5:0] input20_crossing_enable;
	wire [5:0] input21_crossing_enable;
	wire [5:0] input22_crossing_enable;
	wire [9:0] input23_crossing_enable;
	wire [3:0] supply_monitor0_crossing_enable;
	wire [3:0] supply_monitor1_crossing_enable;
	wire wr_mid_sel;
	wire wr_upper_sel;
	genvar g;

	// reset release through two flops
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign input18_crossing_enable = mid_input_irq_enables_r[`TCIE_SWITCH_INPUT_18_MSB:`TCIE_SWITCH_INPUT_18_LSB];
	assign input19_crossing_enable = mid_input_irq_enables_r[`TCIE_SWITCH_INPUT_19_MSB:`TCIE_SWITCH_INPUT_19_LSB];
	assign input20_crossing_enable = mid_input_irq_enables_r[`TCIE_IN20_MSB:`TCIE_IN20_LSB];
	assign input21_crossing_enable = mid_input_irq_enables_r[`TCIE_IN21_MSB:`TCIE_IN21_LSB];
	assign input22_crossing_enable = upper_input_and_supply_irq_enables_r[`TCIE_SWITCH_INPUT_22_MSB:`TCIE_SWITCH_INPUT_22_LSB];
	assign input23_crossing_enable = upper_input_and_supply_irq_enables_r[`TCIE_SWITCH_INPUT_23_MSB:`TCIE_SWITCH_INPUT_23_LSB];
	assign supply_monitor0_crossing_enable = upper_input_and_supply_irq_enables_r[`TCIE_VS0_MSB:`TCIE_VS0_LSB];
	assign supply_monitor1_crossing_enable = upper_input_and_supply_irq_enables_r[`TCIE_VS1_MSB:`TCIE_VS1_LSB];

	// pair k of this vector serves ABOVE_THRESHOLD[k]
	// low end of the vector is input 18 threshold A
	assign enable_pairs = {
		supply_monitor1_crossing_enable,
		supply_monitor0_crossing_enable,
		input23_crossing_enable,
		input22_crossing_enable,
		input21_crossing_enable,
		input20_crossing_enable,
		input19_crossing_enable,
		input18_crossing_enable
	};

	generate
		for (g = 0; g < `TCIE_NSUB; g = g + 1) begin : sub
			tcie_edge u_edge (
				.clk(CLK_SYS),
				.rst_n(rst_sync_r),
				.sample_stb(SAMPLE_STB),
				.above(ABOVE_THRESHOLD[g]),
				.enable_code(enable_pairs[2*g+1:2*g]),
				.hit(hit_vec[g])
			);
		end
	endgenerate

	// write decode: any other address is ignored
	assign wr_mid_sel = REG_WR & (REG_ADDR == `TCIE_OFS_MID_EN);
	assign wr_upper_sel = REG_WR & (REG_ADDR == `TCIE_OFS_UPPER_EN);

	// mid bank, read/write, resets to zero
	always @(posedge CLK_SYS or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			mid_input_irq_enables_r <= `TCIE_RST_MID_EN;
		end else if (wr_mid_sel) begin
			mid_input_irq_enables_r <= REG_WDATA;
		end
	end

	// upper bank, read/write, resets to zero
	always @(posedge CLK_SYS or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			upper_input_and_supply_irq_enables_r <= `TCIE_RST_UPPER_EN;
		end else if (wr_upper_sel) begin
			upper_input_and_supply_irq_enables_r <= REG_WDATA;
		end
	end

	// read mux; a write in the same cycle is seen only by the next read
	always @* begin
		rdata_nxt = {`TCIE_DATA_W{1'b0}};
		case (REG_ADDR)
			`TCIE_OFS_MID_EN: begin
				rdata_nxt = mid_input_irq_enables_r;
			end
			`TCIE_OFS_UPPER_EN: begin
				rdata_nxt = upper_input_and_supply_irq_enables_r;
			end
			default: begin
				// unmapped addresses read zero
				rdata_nxt = {`TCIE_DATA_W{1'b0}};
			end
		endcase
	end

	// read valid pulses one cycle after the strobe
	always @(posedge CLK_SYS or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			REG_RD_VALID <= 1'b0;
		end else begin
			REG_RD_VALID <= REG_RD;
		end
	end

	// read data holds until the next read
	always @(posedge CLK_SYS or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			REG_RDATA <= {`TCIE_DATA_W{1'b0}};
		end else if (REG_RD) begin
			REG_RDATA <= rdata_nxt;
		end
	end

	// supply B pairs decode like all others
	always @(posedge CLK_SYS or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			CROSSING_HIT <= {`TCIE_NSUB{1'b0}};
		end else begin
			CROSSING_HIT <= hit_vec;
		end
	end

	always @(posedge CLK_SYS or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			CROSSING_IRQ <= 1'b0;
		end else begin
			CROSSING_IRQ <= |hit_vec;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/tcie_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tcie_chk (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire [5:0] REG_ADDR,
	input wire [23:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [23:0] REG_RDATA,
	input wire REG_RD_VALID,
	input wire SAMPLE_STB,
	input wire [23:0] ABOVE_THRESHOLD,
	input wire [23:0] CROSSING_HIT,
	input wire CROSSING_IRQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	read_answer_a: assert property (REG_RD |=> REG_RD_VALID) else $error("read not answered");
	answer_cause_a: assert property (REG_RD_VALID |-> $past(REG_RD)) else $error("stray read valid");
	rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
	unmapped_zero_a: assert property (REG_RD && REG_ADDR != 6'h27 && REG_ADDR != 6'h28 |=> REG_RDATA == 24'h0)
		else $error("unmapped read not zero");
	upper_rw_a: assert property (REG_WR && REG_ADDR == 6'h28 ##1 REG_RD && !REG_WR && REG_ADDR == 6'h28
		|=> REG_RDATA == $past(REG_WDATA, 2)) else $error("upper bank readback");
	mid_rw_a: assert property (REG_WR && REG_ADDR == 6'h27 ##1 REG_RD && !REG_WR && REG_ADDR == 6'h27
		|=> REG_RDATA == $past(REG_WDATA, 2)) else $error("mid bank readback");
	irq_or_a: assert property (CROSSING_IRQ == |CROSSING_HIT) else $error("irq not or of hits");
	hit_cause_a: assert property (!SAMPLE_STB |=> CROSSING_HIT == 24'h0) else $error("hit without sample");
	cover property (CROSSING_IRQ);
	cover property (REG_RD_VALID && REG_RDATA != 24'h0);
	cover property (SAMPLE_STB ##1 SAMPLE_STB ##1 CROSSING_IRQ);
endmodule
`default_nettype wire

// ===== testbench/tcie_host.sv
`timescale 1ns/1ns
`default_nettype none
module tcie_host (
	input wire clk,
	output reg [5:0] addr = 6'h00,
	output reg [23:0] wdata = 24'h000000,
	output reg wr = 1'b0,
	output reg rd = 1'b0
);
	task acc(input [5:0] a, input [23:0] d, input w);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
	endtask
	// released bus shows inverted values
	task idle;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= ~addr;
		wdata <= ~wdata;
	endtask
endmodule
`default_nettype wire

// ===== testbench/tcie_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module tcie_top_bench;
	reg clk = 0, arst_n = 0, stb = 0, stb_d = 0, primed = 0;
	reg [23:0] abv = 24'h0, prev = 24'h0, h, m;
	reg [47:0] en = 48'h0;
	reg [31:0] r;
	reg [5:0] u;
	reg [23:0] eh[$], er[$];
	integer err_count = 0, checks_done = 0, seed = 32'hE6647385, i, k, n;
	wire [5:0] addr;
	wire [23:0] wdata, rdata, hit;
	wire wr, rd, rdv, irq;
	tcie_host i_tcie_host(.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	tcie_top i_tcie_top(.CLK_SYS(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .REG_RD_VALID(rdv), .SAMPLE_STB(stb), .ABOVE_THRESHOLD(abv),
		.CROSSING_HIT(hit), .CROSSING_IRQ(irq));
	always #5 clk = ~clk;
	always @(posedge clk) stb_d <= stb;
	task chk(input [63:0] nm, input [23:0] x, input [23:0] g);
		checks_done = checks_done + 1;
		if (g !== x) begin
			err_count = err_count + 1;
			$display("Error %0s expected %h seen %h", nm, x, g);
		end
	endtask
	task rdq(input [5:0] a, input [23:0] x);
		er.push_back(x);
		i_tcie_host.acc(a, 24'h0, 1'b0);
	endtask
	task smp(input [23:0] v);
		@(posedge clk);
		stb <= 1'b1;
		abv <= v;
		for (k = 0; k < 24; k = k + 1)
			h[k] = primed && ((en[2*k] && !prev[k] && v[k]) || (en[2*k+1] && prev[k] && !v[k]));
		eh.push_back(h);
		prev = v;
		primed = 1;
	endtask
	task stop_test;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(negedge clk) begin
		if (stb_d) begin
			m = eh.pop_front();
			chk("hit", m, hit);
			chk("irq", {23'h0, |m}, {23'h0, irq});
		end
		if (rdv === 1'b1)
			chk("rdata", er.pop_front(), rdata);
	end
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdq(6'h27, 24'h0);
		rdq(6'h28, 24'h0);
		rdq(6'h3F, 24'h0);
		for (n = 0; n < 6; n = n + 1) begin
			r = $random(seed);
			en[23:0] = r[23:0];
			r = $random(seed);
			en[47:24] = r[23:0];
			u = n[0] ? 6'h27 : 6'h28;
			i_tcie_host.acc(u ^ 6'h0F, u[0] ? en[47:24] : en[23:0], 1'b1);
			i_tcie_host.acc(u, u[0] ? en[23:0] : en[47:24], 1'b1);
			rdq(u, u[0] ? en[23:0] : en[47:24]);
			rdq(u ^ 6'h0F, u[0] ? en[47:24] : en[23:0]);
			i_tcie_host.idle;
			for (i = 0; i < 16; i = i + 1) begin
				r = $random(seed);
				smp(r[23:0]);
			end
			@(posedge clk);
			stb <= 1'b0;
			abv <= ~abv;
		end
		i_tcie_host.acc(6'h29, ~en[23:0], 1'b1);
		rdq(6'h27, en[23:0]);
		rdq(6'h28, en[47:24]);
		i_tcie_host.idle;
		repeat (4) @(posedge clk);
		chk("queue", 24'h0, 24'(eh.size() + er.size()));
		stop_test;
	end
endmodule
bind tcie_top tcie_chk i_tcie_chk(.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RD_VALID(REG_RD_VALID), .SAMPLE_STB(SAMPLE_STB),
	.ABOVE_THRESHOLD(ABOVE_THRESHOLD), .CROSSING_HIT(CROSSING_HIT), .CROSSING_IRQ(CROSSING_IRQ));
`default_nettype wire
